// ==== core/spi_eeprom_regs.svh ====
// Purpose: Constants of the serial EEPROM command and status front end
// Assumes: System clock of 100 MHz, serial clock well below a tenth of it
// Notes:   Bit positions, opcodes and timing counts live here
`ifndef SPI_EEPROM_REGS_SVH
`define SPI_EEPROM_REGS_SVH

// Opcodes
`define OP_PERMIT_WRITES  8'h06
`define OP_FORBID_WRITES  8'h04
`define OP_STATUS_READ    8'h05
`define OP_STATUS_WRITE   8'h01
`define OP_ARRAY_READ     8'h03
`define OP_ARRAY_WRITE    8'h02

// Status register field positions
`define STAT_LOCK_BIT     7
`define STAT_GUARD_HI     3
`define STAT_GUARD_LO     2
`define STAT_PERMIT_BIT   1
`define STAT_BUSY_BIT     0
`define STAT_RESET        8'h00

// Timing
`define CLK_FREQ_MHZ      100
`define WRITE_TIME_US     5000
`define WRITE_CYCLES      (`WRITE_TIME_US * `CLK_FREQ_MHZ)

`endif

// ==== core/spi_eeprom_pkg.sv ====
// Purpose: Types shared by the serial EEPROM front end
// Assumes: Nothing beyond the constants header
// Notes:   Types only; numbers stay in the header
package spi_eeprom_pkg;
   typedef enum logic [3:0] {
      ST_IDLE, ST_OPCODE, ST_ADDR, ST_WR_DATA, ST_SR_DATA,
      ST_SR_ARMED, ST_STAT_OUT, ST_READ_OUT, ST_WAIT_DESEL, ST_IGNORE
   } front_state_t;

   typedef enum logic [1:0] {
      PEND_NONE, PEND_PERMIT, PEND_FORBID
   } latch_pend_t;
endpackage

// ==== core/pin_events_if.sv ====
// Purpose: Carries synchronised pin levels and edges to the command core
// Assumes: One system clock domain on both ends
// Notes:   Edges are one-cycle pulses
`timescale 1ns/1ns
`default_nettype none
interface pin_events_if;
   logic sclk_rise;
   logic sclk_fall;
   logic sel_rise;
   logic sel_fall;
   logic selected;
   logic din;
   logic paused;
   logic wp_low;

   modport sync (output sclk_rise, sclk_fall, sel_rise, sel_fall, selected, din, paused, wp_low);
   modport core (input  sclk_rise, sclk_fall, sel_rise, sel_fall, selected, din, paused, wp_low);
endinterface
`default_nettype wire

// ==== core/pin_sync.sv ====
// Purpose: Two-flop synchronisers and edge finders for the serial pins
// Assumes: Pins are asynchronous to clk_sys_i
// Notes:   Edges compare the second and third flops only
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
   input  wire logic  clk_sys_i,
   input  wire logic  rstn_i,
   input  wire logic  sclk_i,
   input  wire logic  sel_n_i,
   input  wire logic  din_i,
   input  wire logic  hold_n_i,
   input  wire logic  wp_n_i,
   pin_events_if.sync ev
);
   logic [4:0] meta_r;
   logic [4:0] sync_r;
   logic       sclk_d_r;
   logic       sel_d_r;

   // ---------------------------------------------------------------
   // Synchronisers
   // ---------------------------------------------------------------
   // Select resets as low so a pin already low at power-up gives no fall
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         meta_r   <= 5'h00;
         sync_r   <= 5'h00;
         sclk_d_r <= 1'b0;
         sel_d_r  <= 1'b0;
      end else begin
         meta_r   <= {wp_n_i, hold_n_i, din_i, sel_n_i, sclk_i};
         sync_r   <= meta_r;
         sclk_d_r <= sync_r[0];
         sel_d_r  <= sync_r[1];
      end
   end

   // Edge pulses and levels
   assign ev.sclk_rise = sync_r[0] & ~sclk_d_r;
   assign ev.sclk_fall = ~sync_r[0] & sclk_d_r;
   assign ev.sel_fall  = ~sync_r[1] & sel_d_r;
   assign ev.sel_rise  = sync_r[1] & ~sel_d_r;
   assign ev.selected  = ~sync_r[1];
   assign ev.din       = sync_r[2];
   assign ev.paused    = ~sync_r[1] & ~sync_r[3];
   assign ev.wp_low    = ~sync_r[4];
endmodule
`default_nettype wire

// ==== core/write_timer.sv ====
// Purpose: Self-timed write cycle counter
// Assumes: start_i is a one-cycle pulse, ignored while busy
// Notes:   Count is a parameter so simulation can shorten it
`timescale 1ns/1ns
`default_nettype none
`include "spi_eeprom_regs.svh"
module write_timer #(
   parameter int unsigned CYCLES = `WRITE_CYCLES
) (
   input  wire logic clk_sys_i,
   input  wire logic rstn_i,
   input  wire logic start_i,
   output logic      busy_o,
   output logic      done_o
);
   localparam int W = $clog2(CYCLES + 1);
   logic [W-1:0] cnt_r;

   if (CYCLES < 2) begin : g_chk
      $error("write_timer: CYCLES must be at least 2");
   end

   // ---------------------------------------------------------------
   // Counter
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         busy_o <= 1'b0;
         done_o <= 1'b0;
         cnt_r  <= '0;
      end else begin
         done_o <= 1'b0;
         if (!busy_o && start_i) begin
            busy_o <= 1'b1;
            cnt_r  <= W'(CYCLES - 1);
         end else if (busy_o) begin
            // Done stands in the last busy cycle so its users update with the busy fall
            done_o <= (cnt_r == W'(1));
            if (cnt_r == '0) begin
               busy_o <= 1'b0;
            end else begin
               cnt_r <= cnt_r - 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== core/spi_eeprom_front.sv ====
// Purpose: Serial front end of an EEPROM: opcodes, permit latch, status
// Assumes: Serial clock at most a tenth of clk_sys_i; array memory outside
// Notes:   Array read data must be valid the cycle after arr_rd_req_o
`timescale 1ns/1ns
`default_nettype none
`include "spi_eeprom_regs.svh"
module spi_eeprom_front #(
   parameter int unsigned ADDR_W       = 15,
   parameter int unsigned PAGE_W       = 6,
   parameter int unsigned WRITE_CYCLES = `WRITE_CYCLES
) (
   input  wire logic              clk_sys_i,
   input  wire logic              rstn_i,
   input  wire logic              sclk_i,
   input  wire logic              sel_n_i,
   input  wire logic              din_i,
   input  wire logic              hold_n_i,
   input  wire logic              wp_n_i,
   output logic                   dout_o,
   output logic                   dout_oe_o,
   output logic                   arr_rd_req_o,
   output logic [ADDR_W-1:0]      arr_rd_addr_o,
   input  wire logic [7:0]        arr_rd_data_i,
   output logic                   arr_wr_byte_o,
   output logic [ADDR_W-1:0]      arr_wr_addr_o,
   output logic [7:0]             arr_wr_data_o,
   output logic                   arr_wr_commit_o,
   input  wire logic              arr_wr_ack_unused_i,
   output logic                   standby_o,
   output logic [7:0]             status_o
);
   if (ADDR_W < 3 || ADDR_W > 16 || PAGE_W < 1 || PAGE_W >= ADDR_W) begin : g_chk
      $error("spi_eeprom_front: unsupported ADDR_W or PAGE_W");
   end

   pin_events_if ev ();

   spi_eeprom_pkg::front_state_t state_r;
   spi_eeprom_pkg::latch_pend_t  pend_r;
   logic [2:0]        bit_cnt_r;
   logic [6:0]        rx_r;
   logic [7:0]        rx_byte;
   logic              byte_done;
   logic              active_rise;
   logic              active_fall;
   logic              is_read_r;
   logic              addr_hi_done_r;
   logic [15:0]       addr_r;
   logic              wr_any_r;
   logic [2:0]        tx_cnt_r;
   logic [7:0]        tx_r;
   logic [7:0]        rd_buf_r;
   logic              rd_cap_r;
   logic              rd_first_r;
   logic              out_en_r;
   logic              dout_r;
   logic              write_permit_latch_r;
   logic              lock_r;
   logic [1:0]        guard_r;
   logic [7:0]        sr_new_r;
   logic              sr_cycle_r;
   logic              start_cycle;
   logic              cycle_busy_flag;
   logic              cycle_done;
   logic              hw_locked;
   logic [7:0]        status;
   logic              wr_byte_r;
   logic              rd_req_r;
   logic              commit_r;

   // ---------------------------------------------------------------
   // Pin synchronisation and write cycle timer
   // ---------------------------------------------------------------
   pin_sync u_sync (
      .clk_sys_i (clk_sys_i),
      .rstn_i    (rstn_i),
      .sclk_i    (sclk_i),
      .sel_n_i   (sel_n_i),
      .din_i     (din_i),
      .hold_n_i  (hold_n_i),
      .wp_n_i    (wp_n_i),
      .ev        (ev)
   );

   write_timer #(
      .CYCLES (WRITE_CYCLES)
   ) u_timer (
      .clk_sys_i (clk_sys_i),
      .rstn_i    (rstn_i),
      .start_i   (start_cycle),
      .busy_o    (cycle_busy_flag),
      .done_o    (cycle_done)
   );

   // ---------------------------------------------------------------
   // Helper functions
   // ---------------------------------------------------------------
   // Guarded region test on the upper address bits
   function automatic logic in_guard(input logic [1:0] g, input logic [15:0] a);
      logic [1:0] top;
      top = a[ADDR_W-1 -: 2];
      case (g)
         2'b01:   in_guard = (top == 2'b11);
         2'b10:   in_guard = top[1];
         2'b11:   in_guard = 1'b1;
         default: in_guard = 1'b0;
      endcase
   endfunction

   // Next address within the same page, upper bits held
   function automatic logic [15:0] page_inc(input logic [15:0] a);
      logic [15:0] n;
      n = a;
      n[PAGE_W-1:0] = a[PAGE_W-1:0] + 1'b1;
      page_inc = n;
   endfunction

   // ---------------------------------------------------------------
   // Status byte and protection
   // ---------------------------------------------------------------
   // Upper unused bits stay zero by construction
   always_comb begin
      status = `STAT_RESET;
      status[`STAT_LOCK_BIT]                  = lock_r;
      status[`STAT_GUARD_HI:`STAT_GUARD_LO]   = guard_r;
      status[`STAT_PERMIT_BIT]                = write_permit_latch_r;
      status[`STAT_BUSY_BIT]                  = cycle_busy_flag;
   end
   assign status_o  = status;
   assign hw_locked = lock_r & ev.wp_low;

   // Serial edges count only while selected and not paused
   assign active_rise = ev.sclk_rise & ev.selected & ~ev.paused;
   assign active_fall = ev.sclk_fall & ev.selected & ~ev.paused;
   assign rx_byte     = {rx_r, ev.din};
   assign byte_done   = active_rise && (bit_cnt_r == 3'd7);

   // Self-timed cycles start on the select rise of a valid write
   assign start_cycle = ev.sel_rise && !cycle_busy_flag &&
                        ((state_r == spi_eeprom_pkg::ST_SR_ARMED) ||
                         (state_r == spi_eeprom_pkg::ST_WR_DATA && wr_any_r && bit_cnt_r == 3'd0));

   // ---------------------------------------------------------------
   // Input shifter
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         bit_cnt_r <= 3'd0;
         rx_r      <= 7'h00;
      end else if (ev.sel_fall || ev.sel_rise) begin
         bit_cnt_r <= 3'd0;
      end else if (active_rise) begin
         bit_cnt_r <= bit_cnt_r + 3'd1;
         rx_r      <= rx_byte[6:0];
      end
   end

   // ---------------------------------------------------------------
   // Command state machine
   // ---------------------------------------------------------------
   // Select rise always ends the transaction; only a fall opens one
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         state_r        <= spi_eeprom_pkg::ST_IDLE;
         pend_r         <= spi_eeprom_pkg::PEND_NONE;
         is_read_r      <= 1'b0;
         addr_hi_done_r <= 1'b0;
      end else if (ev.sel_rise) begin
         state_r <= spi_eeprom_pkg::ST_IDLE;
         pend_r  <= spi_eeprom_pkg::PEND_NONE;
      end else if (ev.sel_fall) begin
         state_r        <= spi_eeprom_pkg::ST_OPCODE;
         addr_hi_done_r <= 1'b0;
      end else if (byte_done) begin
         case (state_r)
            spi_eeprom_pkg::ST_OPCODE: begin
               case (rx_byte)
                  `OP_PERMIT_WRITES: begin
                     state_r <= spi_eeprom_pkg::ST_WAIT_DESEL;
                     pend_r  <= spi_eeprom_pkg::PEND_PERMIT;
                  end
                  `OP_FORBID_WRITES: begin
                     state_r <= spi_eeprom_pkg::ST_WAIT_DESEL;
                     pend_r  <= spi_eeprom_pkg::PEND_FORBID;
                  end
                  `OP_STATUS_READ: state_r <= spi_eeprom_pkg::ST_STAT_OUT;
                  `OP_STATUS_WRITE: begin
                     if (write_permit_latch_r && !cycle_busy_flag && !hw_locked) begin
                        state_r <= spi_eeprom_pkg::ST_SR_DATA;
                     end else begin
                        state_r <= spi_eeprom_pkg::ST_IGNORE;
                     end
                  end
                  `OP_ARRAY_READ: begin
                     is_read_r <= 1'b1;
                     state_r   <= cycle_busy_flag ? spi_eeprom_pkg::ST_IGNORE : spi_eeprom_pkg::ST_ADDR;
                  end
                  `OP_ARRAY_WRITE: begin
                     is_read_r <= 1'b0;
                     state_r   <= (write_permit_latch_r && !cycle_busy_flag) ? spi_eeprom_pkg::ST_ADDR
                                                                             : spi_eeprom_pkg::ST_IGNORE;
                  end
                  default: state_r <= spi_eeprom_pkg::ST_IGNORE;
               endcase
            end
            spi_eeprom_pkg::ST_ADDR: begin
               addr_hi_done_r <= 1'b1;
               if (addr_hi_done_r) begin
                  if (is_read_r) begin
                     state_r <= spi_eeprom_pkg::ST_READ_OUT;
                  end else if (in_guard(guard_r, {addr_r[7:0], rx_byte})) begin
                     state_r <= spi_eeprom_pkg::ST_IGNORE;
                  end else begin
                     state_r <= spi_eeprom_pkg::ST_WR_DATA;
                  end
               end
            end
            spi_eeprom_pkg::ST_SR_DATA: state_r <= spi_eeprom_pkg::ST_SR_ARMED;
            default: state_r <= state_r;
         endcase
      end else if (active_rise && state_r == spi_eeprom_pkg::ST_SR_ARMED) begin
         state_r <= spi_eeprom_pkg::ST_IGNORE;
      end
   end

   // ---------------------------------------------------------------
   // Address and array write strobes
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         addr_r    <= 16'h0000;
         wr_any_r  <= 1'b0;
         wr_byte_r <= 1'b0;
         sr_new_r  <= `STAT_RESET;
      end else begin
         wr_byte_r <= 1'b0;
         if (ev.sel_fall) begin
            wr_any_r <= 1'b0;
         end else if (byte_done && state_r == spi_eeprom_pkg::ST_ADDR) begin
            addr_r <= {addr_r[7:0], rx_byte};
         end else if (byte_done && state_r == spi_eeprom_pkg::ST_WR_DATA) begin
            wr_byte_r <= 1'b1;
            wr_any_r  <= 1'b1;
            sr_new_r  <= rx_byte;
         end else if (byte_done && state_r == spi_eeprom_pkg::ST_SR_DATA) begin
            sr_new_r <= rx_byte;
         end else if (wr_byte_r) begin
            addr_r <= page_inc(addr_r); // Rolls inside the page
         end else if (rd_req_r) begin
            addr_r <= addr_r + 16'h0001;
         end
      end
   end
   assign arr_wr_byte_o   = wr_byte_r;
   assign arr_wr_addr_o   = addr_r[ADDR_W-1:0];
   assign arr_wr_data_o   = sr_new_r;
   assign arr_wr_commit_o = commit_r;

   // Commit pulse marks the start of the array cycle
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         commit_r <= 1'b0;
      end else begin
         commit_r <= start_cycle && (state_r == spi_eeprom_pkg::ST_WR_DATA);
      end
   end

   // ---------------------------------------------------------------
   // Write permit latch and protection bits
   // ---------------------------------------------------------------
   // A permit at the same edge as a cycle end wins, so it is never lost
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         write_permit_latch_r <= 1'b0;
      end else if (ev.sel_rise && state_r == spi_eeprom_pkg::ST_WAIT_DESEL &&
                   pend_r == spi_eeprom_pkg::PEND_PERMIT) begin
         write_permit_latch_r <= 1'b1;
      end else if (ev.sel_rise && state_r == spi_eeprom_pkg::ST_WAIT_DESEL &&
                   pend_r == spi_eeprom_pkg::PEND_FORBID) begin
         write_permit_latch_r <= 1'b0;
      end else if (cycle_done) begin
         write_permit_latch_r <= 1'b0;
      end
   end

   // New lock and guard values apply only when the status cycle ends
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         lock_r     <= 1'b0;
         guard_r    <= 2'b00;
         sr_cycle_r <= 1'b0;
      end else begin
         if (start_cycle) begin
            sr_cycle_r <= (state_r == spi_eeprom_pkg::ST_SR_ARMED);
         end
         if (cycle_done && sr_cycle_r) begin
            lock_r  <= sr_new_r[`STAT_LOCK_BIT];
            guard_r <= sr_new_r[`STAT_GUARD_HI:`STAT_GUARD_LO];
         end
      end
   end

   // ---------------------------------------------------------------
   // Array read prefetch
   // ---------------------------------------------------------------
   // Next byte is fetched one bit early so the fall edge never waits
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         rd_req_r   <= 1'b0;
         rd_cap_r   <= 1'b0;
         rd_first_r <= 1'b0;
         rd_buf_r   <= 8'h00;
      end else begin
         rd_req_r <= 1'b0;
         rd_cap_r <= rd_req_r;
         if (byte_done && state_r == spi_eeprom_pkg::ST_ADDR && addr_hi_done_r && is_read_r) begin
            rd_req_r   <= 1'b1;
            rd_first_r <= 1'b1;
         end else if (active_fall && state_r == spi_eeprom_pkg::ST_READ_OUT && tx_cnt_r == 3'd6) begin
            rd_req_r <= 1'b1;
         end
         if (rd_cap_r) begin
            rd_buf_r   <= arr_rd_data_i;
            rd_first_r <= 1'b0;
         end
      end
   end
   assign arr_rd_req_o  = rd_req_r;
   assign arr_rd_addr_o = addr_r[ADDR_W-1:0];

   // ---------------------------------------------------------------
   // Output shifter
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         tx_r     <= 8'h00;
         tx_cnt_r <= 3'd0;
         dout_r   <= 1'b0;
         out_en_r <= 1'b0;
      end else if (ev.sel_rise || ev.sel_fall) begin
         out_en_r <= 1'b0;
         tx_cnt_r <= 3'd0;
      end else if (byte_done && state_r == spi_eeprom_pkg::ST_OPCODE) begin
         tx_r     <= status;
         tx_cnt_r <= 3'd0;
      end else if (rd_cap_r && rd_first_r) begin
         tx_r     <= arr_rd_data_i;
         tx_cnt_r <= 3'd0;
      end else if (active_fall && (state_r == spi_eeprom_pkg::ST_STAT_OUT ||
                                   state_r == spi_eeprom_pkg::ST_READ_OUT)) begin
         out_en_r <= 1'b1;
         dout_r   <= tx_r[7];
         tx_cnt_r <= tx_cnt_r + 3'd1;
         if (tx_cnt_r != 3'd7) begin
            tx_r <= {tx_r[6:0], 1'b0};
         end else if (state_r == spi_eeprom_pkg::ST_STAT_OUT) begin
            tx_r <= status;
         end else begin
            tx_r <= rd_buf_r;
         end
      end
   end

   // Output floats when deselected, paused or refused
   assign dout_o    = dout_r;
   assign dout_oe_o = out_en_r & ev.selected & ~ev.paused & (state_r != spi_eeprom_pkg::ST_IGNORE);
   assign standby_o = ~ev.selected & ~cycle_busy_flag;
endmodule
`default_nettype wire

// ==== sim/spi_eeprom_front_asserts.sv ====
// Purpose: Port-level checks of the serial EEPROM front end
// Assumes: Bound to spi_eeprom_front with its WRITE_CYCLES
// Notes:   Busy length is measured with a small counter
`timescale 1ns/1ns
`default_nettype none
module spi_eeprom_front_asserts #(
   parameter int unsigned WRITE_CYCLES = 50
) (
   input wire logic       clk_sys_i,
   input wire logic       rstn_i,
   input wire logic       sclk_i,
   input wire logic       sel_n_i,
   input wire logic       hold_n_i,
   input wire logic       dout_o,
   input wire logic       dout_oe_o,
   input wire logic       arr_wr_commit_o,
   input wire logic       standby_o,
   input wire logic [7:0] status_o
);
   int unsigned busy_len_r;
   // Counts busy cycles; cleared when idle so a reset mid-cycle starts fresh
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i || !status_o[0]) begin
         busy_len_r <= 0;
      end else begin
         busy_len_r <= busy_len_r + 1;
      end
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   // Synchroniser needs a few cycles, hence four settled cycles
   sequence desel_settled; sel_n_i [*4]; endsequence
   sequence pause_settled; !hold_n_i [*4]; endsequence
   sequence busy_run; status_o[0] && $past(status_o[0]); endsequence
   a_sel_float: assert property (desel_settled |-> !dout_oe_o)
      else $error("output driven while deselected");
   a_pause_float: assert property (pause_settled |-> !dout_oe_o)
      else $error("output driven while paused");
   a_busy_awake: assert property (busy_run |-> !standby_o)
      else $error("standby during write cycle");
   a_zero_bits: assert property (status_o[6:4] == 3'b000)
      else $error("status bits 6 to 4 not zero");
   a_out_on_fall: assert property ($changed(dout_o) && dout_oe_o |-> !$past(sclk_i, 2))
      else $error("output changed away from a falling edge");
   a_busy_length: assert property ($fell(status_o[0]) |-> busy_len_r == WRITE_CYCLES)
      else $error("write cycle length wrong");
   a_end_clears: assert property ($fell(status_o[0]) |-> !status_o[1])
      else $error("permit latch kept after write cycle");
   a_old_status: assert property (busy_run |-> $stable(status_o[7:2]))
      else $error("lock or guard changed during cycle");
   a_permit_late: assert property ($rose(status_o[1]) |-> sel_n_i && $past(sel_n_i, 2))
      else $error("permit set before deselect");
   a_commit_permit: assert property (arr_wr_commit_o |-> status_o[1] ##[0:2] status_o[0])
      else $error("commit without permit or busy");
endmodule
bind spi_eeprom_front spi_eeprom_front_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) chk_i (
   .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .sclk_i(sclk_i), .sel_n_i(sel_n_i), .hold_n_i(hold_n_i),
   .dout_o(dout_o), .dout_oe_o(dout_oe_o), .arr_wr_commit_o(arr_wr_commit_o), .standby_o(standby_o),
   .status_o(status_o));
`default_nettype wire

// ==== sim/spi_host_model.sv ====
// Purpose: Serial host that drives clock, select, data, pause, protect
// Assumes: Mode 0, 125 ns serial period, MSB first
// Notes:   Released output reads as the inverse of the last bit driven
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
   output logic     sclk_o,
   output logic     sel_n_o,
   output logic     din_o,
   output logic     hold_n_o,
   output logic     wp_n_o,
   input wire logic dout_i,
   input wire logic dout_oe_i
);
   logic oe_seen;
   logic hp;
   wire  dq = dout_oe_i ? dout_i : ~dout_i;
   // Select starts high so the first instruction follows a fresh fall
   initial begin
      {sclk_o, din_o, oe_seen, hp} = 4'b0000;
      {sel_n_o, hold_n_o, wp_n_o} = 3'b111;
   end
   // One byte; data set while clock low, read back at the rise
   task automatic xb(input logic [7:0] b, output logic [7:0] r);
      for (int i = 7; i >= 0; i--) begin
         din_o = b[i];
         #62 sclk_o = 1;
         r[i] = dq;
         oe_seen = oe_seen | dout_oe_i;
         #63 sclk_o = 0;
      end
   endtask
   // Opcode then n bytes; select rises after the last fall, before any rise
   task automatic op(input logic [7:0] c, input logic [7:0] d, input int n, output logic [7:0] r);
      sel_n_o = 0;
      oe_seen = 0;
      #160 xb(c, r);
      for (int k = 0; k < n; k++) begin
         // Pause with the clock low; a clock pulse inside it must be ignored
         if (hp) begin
            #100 hold_n_o = 0;
            #100 sclk_o = 1;
            #100 sclk_o = 0;
            #100 hold_n_o = 1;
            #100;
         end
         xb(d, r);
      end
      #100 sel_n_o = 1;
      din_o = ~din_o;
      #200;
   endtask
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// Purpose: Self-checking bench for the serial EEPROM front end
// Assumes: Host model drives the pins; array side is a one-cycle read model
// Notes:   Write cycle shortened to 2000 clocks to keep the run brief
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin err_count++; $display("[FAIL] %s expected %h seen %h", nm, e, a); end end
module tb;
   localparam int unsigned WC = 2000;
   logic       clk_sys_i, rstn_i, sclk, sel_n, din, hold_n, wp_n, dout, oe, commit;
   logic [7:0] status, r, wdata, wdata_seen;
   logic [7:0] rd_data = 8'h00;
   logic [14:0] rd_addr, waddr, waddr_seen;
   logic       rd_req, wr_byte;
   int         err_count = 0;
   int         n_compared = 0;
   int         n_commit = 0;
   spi_eeprom_front #(.WRITE_CYCLES(WC)) spi_eeprom_front_i (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
      .sclk_i(sclk), .sel_n_i(sel_n), .din_i(din), .hold_n_i(hold_n), .wp_n_i(wp_n), .dout_o(dout),
      .dout_oe_o(oe), .arr_rd_req_o(rd_req), .arr_rd_addr_o(rd_addr), .arr_rd_data_i(rd_data),
      .arr_wr_byte_o(wr_byte), .arr_wr_addr_o(waddr), .arr_wr_data_o(wdata), .arr_wr_commit_o(commit),
      .arr_wr_ack_unused_i(1'b0),
      .standby_o(), .status_o(status));
   spi_host_model spi_host_model_i (.sclk_o(sclk), .sel_n_o(sel_n), .din_o(din), .hold_n_o(hold_n),
      .wp_n_o(wp_n), .dout_i(dout), .dout_oe_i(oe));
   // Free-running system clock
   initial begin
      clk_sys_i = 0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   // Commit pulses counted so refused writes show as no pulse
   always @(posedge clk_sys_i) if (commit === 1'b1) n_commit <= n_commit + 1;
   // Array side: one cycle read latency, last written byte kept for checks
   always @(posedge clk_sys_i) if (rd_req === 1'b1) rd_data <= rd_addr[7:0] ^ 8'hA5;
   always @(posedge clk_sys_i) if (wr_byte === 1'b1) {waddr_seen, wdata_seen} <= {waddr, wdata};
   // Status read of two bytes; the second proves the repeat
   task automatic rd(input string nm, input logic [7:0] e);
      spi_host_model_i.op(8'h05, 8'h00, 2, r);
      `CHK(nm, e, r)
      $display("step %s done", nm);
   endtask
   task automatic cmd(input logic [7:0] c, input logic [7:0] d, input int n);
      spi_host_model_i.op(c, d, n, r);
   endtask
   task stop_test;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Watchdog well beyond the expected 152 us of traffic
   initial begin
      #500_000 err_count++;
      stop_test();
   end
   initial begin
      rstn_i = 0;
      repeat (16) @(posedge clk_sys_i);
      #1 rstn_i = 1;
      #200 rd("reset", 8'h00);
      cmd(8'h06, 8'h00, 0);
      rd("permit", 8'h02);
      cmd(8'h04, 8'h00, 0);
      rd("forbid", 8'h00);
      cmd(8'h01, 8'h8C, 1);
      rd("no permit", 8'h00);
      cmd(8'h06, 8'h00, 0);
      cmd(8'h01, 8'hFF, 1);
      rd("old guard", 8'h03);
      #25_000 rd("new status", 8'h8C);
      cmd(8'h06, 8'h00, 0);
      cmd(8'h02, 8'h00, 3);
      `CHK("guarded", 0, n_commit)
      rd("guard refused", 8'h8E);
      spi_host_model_i.wp_n_o = 0;
      cmd(8'h01, 8'h00, 1);
      rd("locked", 8'h8E);
      spi_host_model_i.wp_n_o = 1;
      cmd(8'h01, 8'h00, 1);
      #25_000 rd("unlocked", 8'h00);
      cmd(8'h06, 8'h00, 0);
      cmd(8'h02, 8'h5A, 3);
      `CHK("commit", 1, n_commit)
      `CHK("write data", 8'h5A, wdata_seen)
      `CHK("write addr", 15'h5A5A, waddr_seen)
      rd("array busy", 8'h03);
      #25_000 cmd(8'h03, 8'h00, 3);
      `CHK("array read", 1'b1, spi_host_model_i.oe_seen)
      `CHK("array data", 8'hA5, r)
      cmd(8'h06, 8'h00, 0);
      spi_host_model_i.hp = 1;
      rd("paused read", 8'h02);
      spi_host_model_i.hp = 0;
      cmd(8'hA5, 8'h05, 1);
      `CHK("unknown", 1'b0, spi_host_model_i.oe_seen)
      rd("after unknown", 8'h02);
      stop_test();
   end
endmodule
`default_nettype wire
